// file: logic/brc_pkg.sv
package brc_pkg;
   // i/o port byte addresses
   localparam logic [15:0] PORT_COMPAT_PM  = 16'h00CA;
   localparam logic [15:0] PORT_RESET_FLAG = 16'h00E0;
   localparam logic [15:0] PORT_FLAG_CLEAR = 16'h00E2;
   localparam logic [15:0] PORT_ADDR_MODE  = 16'h00E4;
   localparam logic [15:0] PORT_BOARD_ID   = 16'h00EC;
   // write values with a defined effect
   localparam logic [7:0]  SOFT_RESET_CMD  = 8'h01;
   localparam logic [7:0]  FLAG_CLEAR_CMD  = 8'h00;
   // identification fields
   localparam int          ID_FAMILY_LSB   = 12;
   localparam int          ID_BOARD_LSB    = 9;
   localparam int          ID_CLOCK_LSB    = 7;
   localparam int          ID_DMA_BIT      = 6;
   localparam int          ID_MEM2_BIT     = 5;
   localparam int          ID_SCSI_BIT     = 4;
   localparam int          ID_EXP_BIT      = 3;
   localparam logic [1:0]  CLK_GRADE_25    = 2'h0;
   localparam logic [1:0]  CLK_GRADE_33    = 2'h1;
   localparam logic [2:0]  MEM_SIZE_8M     = 3'h4;
   localparam logic [2:0]  MEM_SIZE_4M     = 3'h6;
   localparam logic [2:0]  MEM_SIZE_2M     = 3'h7;
   // timing
   localparam int          CLK_PERIOD_PS   = 4000;
   localparam int          TIMEOUT_MS      = 8;
   localparam int          TIMEOUT_CYCLES  = TIMEOUT_MS * (1000000000 / CLK_PERIOD_PS);
   localparam int          SOFT_RESET_NS   = 1000;
   localparam int          SOFT_RESET_CYC  = (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;

   // one i/o request from the processor side
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        word;
      logic [15:0] addr;
      logic [15:0] wdata;
   } brc_io_req_t;

   // per-function reset strobes, active high
   typedef struct packed {
      logic cpu;          // cpu reset, cache flush, real mode
      logic dual_port;
      logic dma;          // dma controller and address generator
      logic refresh;      // refresh logic held, refresh suspended
      logic bus_if;       // system-bus interface and time-out
      logic io;           // scsi fifo/ctrl, parallel, serial, expansion, writes, page
      logic power;        // interrupt controllers and timer, power cycle only
   } brc_resets_t;
endpackage

// file: logic/brc_board_reset.sv
`timescale 1ns/10ps
// Contract
// - reset forces real mode; byte write E4 with D0 set enters protected mode
// - byte write E4 with D0 clear returns to real mode
// - word write to CA enters protected mode
// - 16-bit read-only id at EC; family and board-type fields on top
// - id bits 8:7 report cpu clock grade, 00 or 01
// - id bits 6..3 read zero when module present, one when absent
// - id bits 2:0 encode bottom memory size
// - dma presence caught after power-up; absent forwards its ranges to bus
// - four reset sources: init, aux panel, power-up, software
// - writing 1 to reset port asserts software reset
// - reset port bit 0 reads last reset type, 1 for software
// - byte write of zero to E2 clears reset-type flag
// - untied init resets only bus interface and time-out logic; the code also holds refresh on init
// - narrow software reset: cpu, cache, mode, dual-port, dma, refresh, flag
// - power-up and aux resets also reset all i/o functions
// - tie options make init or software reset act as power-up
// - refresh suspended in any reset; timers reset on power only
// - bus cycle not done in about 8 ms declares time-out
// - force-ready option returns ready and lights led; else keep waiting
// - time-out unaffected by buffered write setting
// - ownership not won in time raises error; clearable latch
// - cache off after reset; only dram accesses may be cached
module brc_board_reset
   import brc_pkg::*;
#(
   parameter int          TIMEOUT_CNT  = TIMEOUT_CYCLES,
   parameter logic [3:0]  FAMILY_CODE  = 4'h5,  // arbitrary value
   parameter logic [2:0]  BOARD_CODE   = 3'h2   // arbitrary value
)(
   input  wire logic        clk_i,
   input  wire logic        reset_i,            // power-up hardware reset
   input  wire logic        hard_reset_n_i,     // power-up reset logic output
   input  wire logic        init_n_i,           // system bus initialise
   input  wire logic        aux_panel_reset_n_i,
   input  wire logic        init_tie_option_i,
   input  wire logic        wide_soft_reset_option_i,
   input  wire logic        timeout_response_option_i, // 1: force ready
   input  wire logic        buffered_writes_i,  // has no effect on time-out
   input  wire brc_io_req_t io_req_i,
   output logic      [15:0] io_rdata_o,
   output logic             io_rvalid_o,
   input  wire logic        dma_present_n_i,
   input  wire logic        mem2_present_n_i,
   input  wire logic        scsi_present_n_i,
   input  wire logic        expansion_present_n_i,
   input  wire logic        clk_grade_33_i,
   input  wire logic  [2:0] mem_size_i,
   input  wire logic        dma_range_hit_i,    // decoded dma/addr-gen/scsi i/o range
   output logic             forward_to_bus_o,
   input  wire logic        bus_cycle_start_i,
   input  wire logic        bus_ack_i,
   input  wire logic        bus_request_i,
   input  wire logic        bus_grant_i,
   input  wire logic        error_latch_clear_n_i,
   input  wire logic        cache_enable_i,
   input  wire logic        mem_is_dram_i,
   output logic             cacheable_o,
   output logic             forced_ready_o,
   output logic             timeout_led_o,
   output logic             bus_timeout_irq_o,
   output logic             bus_request_error_o,
   output logic             latched_error_irq_o,
   output logic             protected_mode_o,
   output logic             soft_reset_n_o,
   output brc_resets_t      resets_o
);

   ////////////////////////////////////////////////////////////////////////////
   // decode
   function automatic logic hit(input brc_io_req_t r, input logic [15:0] a);
      return r.addr == a;
   endfunction

   logic wr_mode, wr_compat, wr_rst, wr_clr, rd_id, rd_rst;
   assign wr_mode   = io_req_i.wr && !io_req_i.word && hit(io_req_i, PORT_ADDR_MODE);
   assign wr_compat = io_req_i.wr && io_req_i.word && hit(io_req_i, PORT_COMPAT_PM);
   assign wr_rst    = io_req_i.wr && hit(io_req_i, PORT_RESET_FLAG);
   assign wr_clr    = io_req_i.wr && !io_req_i.word && hit(io_req_i, PORT_FLAG_CLEAR);
   assign rd_id     = io_req_i.rd && hit(io_req_i, PORT_BOARD_ID);
   assign rd_rst    = io_req_i.rd && hit(io_req_i, PORT_RESET_FLAG);

   ////////////////////////////////////////////////////////////////////////////
   // reset sources and classes
   logic soft_req;
   logic [15:0] soft_cnt_reg;
   logic soft_active;
   logic power_src, init_src, full_reset, narrow_soft;

   assign soft_req    = wr_rst && io_req_i.wdata[7:0] == SOFT_RESET_CMD;
   assign soft_active = soft_cnt_reg != 16'h0000;
   assign power_src   = !hard_reset_n_i || !aux_panel_reset_n_i;
   assign init_src    = !init_n_i;
   // a tie option turns init or software reset into a power-up class reset
   assign full_reset  = power_src || (init_src && init_tie_option_i)
                     || (soft_active && wide_soft_reset_option_i);
   assign narrow_soft = soft_active && !wide_soft_reset_option_i;

   // self-timed software reset pulse, long enough for every target
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         soft_cnt_reg <= 16'h0000;
      end else if (soft_req && !soft_active) begin
         soft_cnt_reg <= 16'(SOFT_RESET_CYC);
      end else if (soft_active) begin
         soft_cnt_reg <= soft_cnt_reg - 16'h0001;
      end
   end

   // per-function strobes, registered so outputs come from flops
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         resets_o       <= '1;
         soft_reset_n_o <= 1'b1;
      end else begin
         soft_reset_n_o      <= !soft_active;
         resets_o.cpu        <= full_reset || narrow_soft;
         resets_o.dual_port  <= full_reset || narrow_soft;
         resets_o.dma        <= full_reset || narrow_soft;
         resets_o.refresh    <= full_reset || narrow_soft || init_src;
         resets_o.bus_if     <= full_reset || init_src;
         resets_o.io         <= full_reset;
         resets_o.power      <= 1'b0;  // only the power-on reset reaches timers
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // addressing mode
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         protected_mode_o <= 1'b0;
      end else if (full_reset || narrow_soft) begin
         protected_mode_o <= 1'b0;
      end else if (wr_compat) begin
         protected_mode_o <= 1'b1;
      end else if (wr_mode) begin
         protected_mode_o <= io_req_i.wdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset-type flag; the flag is rewritten by every reset except an untied init, a reset beats a clear
   logic type_flag_reg;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         type_flag_reg <= 1'b0;
      end else if (power_src || (init_src && init_tie_option_i)) begin
         type_flag_reg <= 1'b0;
      end else if (soft_active) begin
         type_flag_reg <= 1'b1;
      end else if (wr_clr && io_req_i.wdata[7:0] == FLAG_CLEAR_CMD) begin
         type_flag_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // dma presence caught once after power-up release, then kept
   logic dma_absent_reg;
   logic dma_seen_reg;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         dma_absent_reg <= 1'b0;
         dma_seen_reg   <= 1'b0;
      end else if (!dma_seen_reg) begin
         dma_absent_reg <= dma_present_n_i;
         dma_seen_reg   <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         forward_to_bus_o <= 1'b0;
      end else begin
         forward_to_bus_o <= dma_absent_reg && dma_range_hit_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads
   logic [15:0] id_word;
   always_comb begin
      id_word = 16'h0000;
      id_word[ID_FAMILY_LSB +: 4] = FAMILY_CODE;
      id_word[ID_BOARD_LSB +: 3]  = BOARD_CODE;
      id_word[ID_CLOCK_LSB +: 2]  = clk_grade_33_i ? CLK_GRADE_33 : CLK_GRADE_25;
      id_word[ID_DMA_BIT]         = dma_absent_reg;
      id_word[ID_MEM2_BIT]        = mem2_present_n_i;
      id_word[ID_SCSI_BIT]        = scsi_present_n_i;
      id_word[ID_EXP_BIT]         = expansion_present_n_i;
      id_word[2:0]                = mem_size_i;
   end

   // read data one cycle after the request; unmapped reads return zero
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         io_rdata_o  <= 16'h0000;
         io_rvalid_o <= 1'b0;
      end else begin
         io_rvalid_o <= io_req_i.rd;
         if (rd_id) begin
            io_rdata_o <= id_word;
         end else if (rd_rst) begin
            io_rdata_o <= {15'h0000, type_flag_reg};
         end else begin
            io_rdata_o <= 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus time-out; buffered writes do not enter this path at all
   logic [31:0] cyc_cnt_reg;
   logic        cyc_busy_reg;
   logic        cyc_expire;
   assign cyc_expire = cyc_busy_reg && cyc_cnt_reg == 32'(TIMEOUT_CNT - 1);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cyc_busy_reg <= 1'b0;
         cyc_cnt_reg  <= 32'h0000_0000;
      end else if (resets_o.bus_if || bus_ack_i) begin
         cyc_busy_reg <= 1'b0;
         cyc_cnt_reg  <= 32'h0000_0000;
      end else if (bus_cycle_start_i && !cyc_busy_reg) begin
         cyc_busy_reg <= 1'b1;
         cyc_cnt_reg  <= 32'h0000_0000;
      end else if (cyc_expire && timeout_response_option_i) begin
         cyc_busy_reg <= 1'b0;
      end else if (cyc_busy_reg && cyc_cnt_reg != 32'(TIMEOUT_CNT)) begin
         // wait mode steps once past expiry and parks there, so the irq pulses once
         cyc_cnt_reg  <= cyc_cnt_reg + 32'h0000_0001;
      end
   end

   // ready pulse and irq on expiry; led stays lit until the interface resets
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         forced_ready_o    <= 1'b0;
         bus_timeout_irq_o <= 1'b0;
         timeout_led_o     <= 1'b0;
      end else begin
         forced_ready_o    <= cyc_expire && timeout_response_option_i;
         bus_timeout_irq_o <= cyc_expire;
         if (resets_o.bus_if) begin
            timeout_led_o <= 1'b0;
         end else if (cyc_expire && timeout_response_option_i) begin
            timeout_led_o <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ownership wait and error latch
   logic [31:0] req_cnt_reg;
   logic        req_expire;
   assign req_expire = req_cnt_reg == 32'(TIMEOUT_CNT - 1);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         req_cnt_reg <= 32'h0000_0000;
      end else if (resets_o.bus_if || !bus_request_i || bus_grant_i) begin
         req_cnt_reg <= 32'h0000_0000;
      end else if (!req_expire) begin
         req_cnt_reg <= req_cnt_reg + 32'h0000_0001;
      end
   end

   // error set wins over clear; the unstable case is settled as set
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         bus_request_error_o <= 1'b0;
         latched_error_irq_o <= 1'b0;
      end else begin
         bus_request_error_o <= req_expire && bus_request_i && !bus_grant_i
                                && !resets_o.bus_if;
         if (bus_request_error_o) begin
            latched_error_irq_o <= 1'b1;
         end else if (!error_latch_clear_n_i) begin
            latched_error_irq_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cacheability: off during cpu reset, dram only
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cacheable_o <= 1'b0;
      end else begin
         cacheable_o <= cache_enable_i && mem_is_dram_i && !resets_o.cpu;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks; the steps of the longer behaviours are named sequences
   sequence s_soft_held;
      !soft_reset_n_o [*8];
   endsequence
   sequence s_forced_done;
      forced_ready_o ##1 timeout_led_o;
   endsequence

   a_mode_reset_real: assert property (@(posedge clk_i) disable iff (reset_i)
      (full_reset || narrow_soft) |=> !protected_mode_o)
      else $error("mode not real after reset");
   a_mode_byte_write: assert property (@(posedge clk_i) disable iff (reset_i)
      (wr_mode && !wr_compat && !full_reset && !narrow_soft)
      |=> protected_mode_o == $past(io_req_i.wdata[0]))
      else $error("mode write ignored");
   a_compat_enter_pm: assert property (@(posedge clk_i) disable iff (reset_i)
      (wr_compat && !full_reset && !narrow_soft) |=> protected_mode_o)
      else $error("compat write ignored");
   a_id_read_value: assert property (@(posedge clk_i) disable iff (reset_i)
      rd_id |=> io_rvalid_o && io_rdata_o[15:12] == FAMILY_CODE
               && io_rdata_o[6] == dma_absent_reg)
      else $error("id read wrong");
   a_soft_reset_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
      (soft_req && !soft_active) |=> ##1 s_soft_held)
      else $error("soft reset too short");
   a_flag_after_soft: assert property (@(posedge clk_i) disable iff (reset_i)
      (soft_active && !power_src && !init_src) |=> type_flag_reg)
      else $error("flag not set by soft reset");
   a_flag_clear_write: assert property (@(posedge clk_i) disable iff (reset_i)
      (wr_clr && io_req_i.wdata[7:0] == FLAG_CLEAR_CMD && !soft_active
       && !power_src && !init_src) |=> !type_flag_reg)
      else $error("flag not cleared");
   a_init_bus_only: assert property (@(posedge clk_i) disable iff (reset_i)
      (init_src && !init_tie_option_i && !power_src && !soft_active)
      |=> resets_o.bus_if && !resets_o.io && !resets_o.cpu)
      else $error("init reset too wide");
   a_timeout_ready: assert property (@(posedge clk_i) disable iff (reset_i)
      (cyc_expire && timeout_response_option_i && !resets_o.bus_if && !bus_ack_i)
      |=> s_forced_done)
      else $error("forced completion missing");
   a_latch_hold_set: assert property (@(posedge clk_i) disable iff (reset_i)
      bus_request_error_o |=> latched_error_irq_o)
      else $error("error not latched");
   a_cache_dram_only: assert property (@(posedge clk_i) disable iff (reset_i)
      cacheable_o |-> $past(mem_is_dram_i))
      else $error("non-dram access cached");

   // further rule checks
   a_forward_absent: assert property (@(posedge clk_i) disable iff (reset_i)
      (dma_absent_reg && dma_range_hit_i) |=> forward_to_bus_o)
      else $error("absent dma range not forwarded");
   a_power_full_reset: assert property (@(posedge clk_i) disable iff (reset_i)
      power_src |=> resets_o.io && resets_o.cpu && resets_o.bus_if)
      else $error("power-up reset too narrow");
   a_wide_soft_full: assert property (@(posedge clk_i) disable iff (reset_i)
      (soft_active && wide_soft_reset_option_i) |=> resets_o.io && resets_o.bus_if)
      else $error("wide soft reset too narrow");
   a_refresh_held: assert property (@(posedge clk_i) disable iff (reset_i)
      (full_reset || narrow_soft || init_src) |=> resets_o.refresh)
      else $error("refresh not held in reset");
   a_timeout_irq_once: assert property (@(posedge clk_i) disable iff (reset_i)
      cyc_expire |=> bus_timeout_irq_o ##1 !bus_timeout_irq_o)
      else $error("time-out irq not a single pulse");
   a_wait_no_ready: assert property (@(posedge clk_i) disable iff (reset_i)
      (cyc_expire && !timeout_response_option_i) |=> !forced_ready_o)
      else $error("ready forced in wait mode");
   a_error_needs_request: assert property (@(posedge clk_i) disable iff (reset_i)
      bus_request_error_o |-> $past(bus_request_i) && !$past(bus_grant_i))
      else $error("request error without pending request");
   a_latch_clear_low: assert property (@(posedge clk_i) disable iff (reset_i)
      (!error_latch_clear_n_i && !bus_request_error_o) |=> !latched_error_irq_o)
      else $error("error latch not cleared");
   a_cache_off_reset: assert property (@(posedge clk_i) disable iff (reset_i)
      resets_o.cpu |=> !cacheable_o)
      else $error("cache on during cpu reset");

endmodule

// file: dv/brc_bus_model.sv
`timescale 1ns/10ps
// backplane stand-in: a slave that acks bus cycles and an arbiter that grants ownership
module brc_bus_model (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic cycle_start_i,
   input  wire logic request_i,
   input  wire logic ack_en_i,    // 0: slave never answers
   input  wire logic grant_en_i,  // 0: bus never handed over
   output logic      bus_ack_o,
   output logic      bus_grant_o
);
   logic [3:0] ack_cnt_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // slave answers four cycles after the start, well inside the time-out
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_cnt_reg <= 4'h0;
         bus_ack_o   <= 1'b0;
      end else begin
         bus_ack_o <= ack_en_i && (ack_cnt_reg == 4'h1);
         if (cycle_start_i) begin
            ack_cnt_reg <= 4'h4;
         end else if (ack_cnt_reg != 4'h0) begin
            ack_cnt_reg <= ack_cnt_reg - 4'h1;
         end
      end
   end

   // grant one cycle late, dropped one cycle after the request goes away
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         bus_grant_o <= 1'b0;
      end else begin
         bus_grant_o <= grant_en_i && request_i;
      end
   end
endmodule

// file: dv/board_reset_and_control_tb_top.sv
`timescale 1ns/10ps
module board_reset_and_control_tb_top;
   import brc_pkg::*;
   logic        clk_i = 1'b0, reset_i = 1'b1, init_n = 1'b1, aux_n = 1'b1;
   logic        tie = 1'b0, wide = 1'b0, tor = 1'b0, bufw = 1'b0, start = 1'b0;
   logic        req_b = 1'b0, clr_n = 1'b1, cen = 1'b1, dram = 1'b1;
   logic        ack_en = 1'b0, grant_en = 1'b1, ack, grant;
   logic        hard_n = 1'b1, grade = 1'b1, rhit = 1'b1;
   logic [2:0]  msize = MEM_SIZE_4M;
   int          waited = 0;
   localparam int TO_CNT = 20;
   brc_io_req_t req = '0;
   logic [15:0] rdata;
   logic        rvalid, fwd, cach, fready, led, tirq, berr, lirq, pm, srn;
   brc_resets_t rst;
   int          n_errors = 0;
   int          n_compared = 0;

   always #2 clk_i = ~clk_i;

   // short time-out so the expiry paths fit in the run; codes are arbitrary
   brc_board_reset #(.TIMEOUT_CNT(TO_CNT), .FAMILY_CODE(4'h9), .BOARD_CODE(3'h5)) dut (
      .clk_i(clk_i), .reset_i(reset_i), .hard_reset_n_i(hard_n), .init_n_i(init_n),
      .aux_panel_reset_n_i(aux_n), .init_tie_option_i(tie),
      .wide_soft_reset_option_i(wide), .timeout_response_option_i(tor),
      .buffered_writes_i(bufw), .io_req_i(req), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
      .dma_present_n_i(1'b1), .mem2_present_n_i(1'b0), .scsi_present_n_i(1'b1),
      .expansion_present_n_i(1'b0), .clk_grade_33_i(grade), .mem_size_i(msize),
      .dma_range_hit_i(rhit), .forward_to_bus_o(fwd), .bus_cycle_start_i(start),
      .bus_ack_i(ack), .bus_request_i(req_b), .bus_grant_i(grant),
      .error_latch_clear_n_i(clr_n), .cache_enable_i(cen), .mem_is_dram_i(dram),
      .cacheable_o(cach), .forced_ready_o(fready), .timeout_led_o(led),
      .bus_timeout_irq_o(tirq), .bus_request_error_o(berr), .latched_error_irq_o(lirq),
      .protected_mode_o(pm), .soft_reset_n_o(srn), .resets_o(rst));

   brc_bus_model bus (
      .clk_i(clk_i), .reset_i(reset_i), .cycle_start_i(start), .request_i(req_b),
      .ack_en_i(ack_en), .grant_en_i(grant_en), .bus_ack_o(ack), .bus_grant_o(grant));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // inputs always change 1 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic io_wr(input logic [15:0] a, input logic [15:0] d, input logic w);
      req = '{1'b0, 1'b1, w, a, d};
      cyc(1);
      req = '0;
      cyc(1);
   endtask

   // read data stands one cycle, in the cycle after the strobe
   task automatic io_rd(input logic [15:0] a, input logic [15:0] exp);
      req = '{1'b1, 1'b0, 1'b1, a, 16'h0000};
      cyc(1);
      req = '0;
      chk({15'h0000, rvalid}, 16'h0001);
      chk(rdata, exp);
      cyc(1);
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: pick = ~srn;
         1: pick = fready;
         2: pick = berr;
         default: pick = tirq;
      endcase
   endfunction

   // bounded wait for an output to rise; exp 0 means it must stay low throughout
   task automatic wait_for(input int s, input int lim, input logic exp);
      int i;
      for (i = 0; i < lim && pick(s) !== 1'b1; i++) cyc(1);
      waited = i;
      chk({15'h0000, pick(s)}, {15'h0000, exp});
      if (exp && i == lim) summarize();
   endtask

   task automatic pulse_start();
      start = 1'b1;
      cyc(1);
      start = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(5);
      reset_i = 1'b0;
      cyc(2);
      chk({15'h0000, pm}, 16'h0000);
      io_wr(PORT_ADDR_MODE, 16'h0001, 1'b0);
      chk({15'h0000, pm}, 16'h0001);
      io_wr(PORT_ADDR_MODE, 16'h0000, 1'b0);
      chk({15'h0000, pm}, 16'h0000);
      io_wr(PORT_COMPAT_PM, 16'h1234, 1'b1);
      chk({15'h0000, pm}, 16'h0001);
      io_rd(PORT_BOARD_ID, {4'h9, 3'h5, 2'h1, 4'hA, MEM_SIZE_4M});
      grade = 1'b0;
      msize = MEM_SIZE_8M;
      io_rd(PORT_BOARD_ID, {4'h9, 3'h5, CLK_GRADE_25, 4'hA, MEM_SIZE_8M});
      io_rd(16'h00EE, 16'h0000);
      chk({15'h0000, fwd}, 16'h0001);
      chk({15'h0000, cach}, 16'h0001);
      dram = 1'b0;
      rhit = 1'b0;
      cyc(2);
      chk({15'h0000, cach}, 16'h0000);
      chk({15'h0000, fwd}, 16'h0000);
      dram = 1'b1;
      $display("test mode, id and cache done");
      io_wr(PORT_RESET_FLAG, 16'h0002, 1'b0);
      wait_for(0, 5, 1'b0);
      io_wr(PORT_RESET_FLAG, {8'h00, SOFT_RESET_CMD}, 1'b0);
      wait_for(0, 5, 1'b1);
      chk({8'h00, pm, rst}, 16'h0078);
      cyc(1);
      chk({15'h0000, cach}, 16'h0000);
      cyc(SOFT_RESET_CYC + 2);
      chk({15'h0000, srn}, 16'h0001);
      io_rd(PORT_RESET_FLAG, 16'h0001);
      io_wr(PORT_FLAG_CLEAR, 16'h0000, 1'b0);
      io_rd(PORT_RESET_FLAG, 16'h0000);
      wide = 1'b1;
      io_wr(PORT_RESET_FLAG, {8'h00, SOFT_RESET_CMD}, 1'b0);
      wait_for(0, 5, 1'b1);
      chk({9'h000, rst}, 16'h007E);
      cyc(SOFT_RESET_CYC + 2);
      wide = 1'b0;
      $display("test software reset done");
      hard_n = 1'b0;
      cyc(2);
      chk({9'h000, rst}, 16'h007E);
      hard_n = 1'b1;
      cyc(2);
      io_rd(PORT_RESET_FLAG, 16'h0000);
      init_n = 1'b0;
      cyc(2);
      chk({9'h000, rst}, 16'h000C);
      tie = 1'b1;
      cyc(2);
      chk({9'h000, rst}, 16'h007E);
      init_n = 1'b1;
      tie = 1'b0;
      aux_n = 1'b0;
      cyc(2);
      chk({9'h000, rst}, 16'h007E);
      aux_n = 1'b1;
      cyc(2);
      io_rd(PORT_RESET_FLAG, 16'h0000);
      $display("test hardware resets done");
      pulse_start();
      wait_for(3, 40, 1'b1);
      chk(16'(waited), 16'(TO_CNT));
      cyc(1);
      chk({15'h0000, tirq}, 16'h0000);
      wait_for(1, 40, 1'b0);
      chk({15'h0000, led}, 16'h0000);
      init_n = 1'b0;
      cyc(2);
      init_n = 1'b1;
      tor = 1'b1;
      bufw = 1'b1;
      cyc(2);
      pulse_start();
      wait_for(1, 40, 1'b1);
      chk(16'(waited), 16'(TO_CNT));
      chk({15'h0000, tirq}, 16'h0001);
      cyc(1);
      chk({15'h0000, led}, 16'h0001);
      ack_en = 1'b1;
      pulse_start();
      wait_for(1, 40, 1'b0);
      $display("test bus time-out done");
      req_b = 1'b1;
      wait_for(2, 40, 1'b0);
      grant_en = 1'b0;
      req_b = 1'b0;
      cyc(2);
      req_b = 1'b1;
      wait_for(2, 40, 1'b1);
      chk(16'(waited), 16'(TO_CNT));
      cyc(1);
      chk({15'h0000, lirq}, 16'h0001);
      req_b = 1'b0;
      clr_n = 1'b0;
      cyc(1);
      chk({15'h0000, lirq}, 16'h0001);
      cyc(2);
      chk({15'h0000, lirq}, 16'h0000);
      $display("test request error done");
      summarize();
   end

   // guard against a hang anywhere above
   initial begin
      #40000;
      n_errors++;
      summarize();
   end
endmodule
